// >>> host_model.sv
`timescale 1ns/100ps

// Host driving both links; clocks stand still and data inverts when idle.
module host_model
(
    // Clock and readback.
    input  wire clk_sys_i,
    input  wire readback_i,
    // Links.
    output reg  sclk_o = 1'b1,
    output reg  sel_o = 1'b1,
    output reg  sdo_o = 1'b0,
    output reg  [7:0] rb_o = 8'h00,
    output reg  dclk_o = 1'b0,
    output reg  dsd_o = 1'b0,
    output reg  stb_o = 1'b0
);
    integer i;
    // One refresh of the driver, eight bits MSB first.
    task drv_frame(input [7:0] v, input sel);
        begin
            @(negedge clk_sys_i);
            sel_o = !sel;
            #100;
            // Each readback bit is taken before the fall that shifts it out.
            for (i = 7; i >= 0; i = i - 1)
            begin
                rb_o[i] = readback_i;
                sdo_o = v[i];
                #40 sclk_o = 1'b0;
                #40 sclk_o = 1'b1;
            end
            sdo_o = !v[0];
            #40 sel_o = 1'b1;
            #200;
        end
    endtask
    // Ten bits enable first, then a strobe pulse.
    task disp_frame(input [9:0] f, input s);
        begin
            @(negedge clk_sys_i);
            for (i = 9; i >= 0; i = i - 1)
            begin
                dsd_o = f[i];
                #40 dclk_o = 1'b1;
                #40 dclk_o = 1'b0;
            end
            dsd_o = !f[0];
            stb_o = s;
            #80 stb_o = 1'b0;
            #200;
        end
    endtask
endmodule

// >>> pin_sync.v
`timescale 1ns/100ps

// Two-stage synchroniser with a registered copy for edge detection.
module pin_sync
#(
    parameter IDLE = 1'b0
)
(
    // Clock and reset.
    input  wire clk_sys_i,
    input  wire rst_i,
    // Asynchronous pin and its synchronised forms.
    input  wire pin_i,
    output wire level_o,
    output wire rise_o,
    output wire fall_o
);

    reg meta_reg;
    reg sync_reg;
    reg prev_reg;

    // The first stage is read only by the second stage. Every stage resets
    // to the pin's idle level, so no false edge follows reset.
    always @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            meta_reg <= IDLE;
            sync_reg <= IDLE;
            prev_reg <= IDLE;
        end
        else
        begin
            meta_reg <= pin_i;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // Edge pulses last one system clock.
    assign level_o = sync_reg;
    assign rise_o  = sync_reg & ~prev_reg;
    assign fall_o  = ~sync_reg & prev_reg;

endmodule

// >>> serial_latch_checker.sv
`timescale 1ns/100ps

// Port-level assertions for the latch interface.
module serial_latch_checker
(
    // Clock and reset.
    input wire       clk_sys_i,
    input wire       rst_i,
    // Watched ports.
    input wire       serial_frame_select_i,
    input wire       disp_strobe_i,
    input wire [7:0] driver_outputs_o,
    input wire [7:0] lcd_parallel_data_o,
    input wire       register_select_bit_o,
    input wire       display_enable_bit_o,
    input wire       lcd_byte_valid_o,
    input wire [7:0] lcd_byte_o,
    input wire       lcd_byte_is_data_o
);
    reg [7:0] stb_seen;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // Recent strobe history.
    always @(posedge clk_sys_i)
        stb_seen <= {stb_seen[6:0], disp_strobe_i};
    // Link checks.
    a_drv_after_frame: assert property (
        $changed(driver_outputs_o) |-> serial_frame_select_i)
        else $error("driver outputs moved inside a frame");
    a_latch_hold: assert property (
        $changed({display_enable_bit_o, register_select_bit_o,
        lcd_parallel_data_o}) |-> |stb_seen)
        else $error("latch moved with strobe low");
    a_byte_pulse: assert property (
        lcd_byte_valid_o |=> !lcd_byte_valid_o)
        else $error("byte pulse too long");
    a_byte_on_fall: assert property (
        $fell(display_enable_bit_o) |-> ##[0:4] lcd_byte_valid_o)
        else $error("no byte after enable fell");
    a_byte_enable_low: assert property (
        lcd_byte_valid_o |-> !display_enable_bit_o)
        else $error("byte taken with enable high");
    a_byte_value: assert property (
        lcd_byte_valid_o |-> lcd_byte_o == lcd_parallel_data_o)
        else $error("byte differs from data lines");
    a_byte_kind: assert property (
        lcd_byte_valid_o |-> lcd_byte_is_data_o == register_select_bit_o)
        else $error("byte kind differs from select bit");
    c_data: cover property (lcd_byte_valid_o && lcd_byte_is_data_o);
    c_cmd: cover property (lcd_byte_valid_o && !lcd_byte_is_data_o);
    c_drv: cover property ($changed(driver_outputs_o));
endmodule

bind serial_output_latch_interface serial_latch_checker CHK
(
    .clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .serial_frame_select_i(serial_frame_select_i),
    .disp_strobe_i(disp_strobe_i), .driver_outputs_o(driver_outputs_o),
    .lcd_parallel_data_o(lcd_parallel_data_o),
    .register_select_bit_o(register_select_bit_o),
    .display_enable_bit_o(display_enable_bit_o),
    .lcd_byte_valid_o(lcd_byte_valid_o), .lcd_byte_o(lcd_byte_o),
    .lcd_byte_is_data_o(lcd_byte_is_data_o)
);

// >>> serial_latch_defs.vh
`ifndef SERIAL_LATCH_DEFS_VH
`define SERIAL_LATCH_DEFS_VH

// Width of the peripheral driver and display shift registers.
`define DRV_WIDTH          8
`define DISP_WIDTH         10
// Display shift stage positions of the two control bits.
`define DISP_RS_BIT        8
`define DISP_EN_BIT        9
// Reset values of the latched outputs.
`define DRV_RESET_VALUE    8'h00
`define DISP_RESET_VALUE   10'h000
// Depth of the pin synchroniser.
`define SYNC_STAGES        2

`endif

// >>> serial_output_latch_interface.v
// Functional notes
// - Falling frame select loads the eight driver output states for readback.
// - Driver shift register samples serial data on falling shift clock.
// - Display shift register takes serial data on rising clock.
// - Latches follow shift stages while strobe high, hold while low.
// - Display takes the parallel byte on enable high-to-low transition.
// - Register select bit marks each byte command or data; enable bit strobes it.
`timescale 1ns/100ps
`include "serial_latch_defs.vh"

module serial_output_latch_interface
#(
    parameter DRV_WIDTH  = `DRV_WIDTH,
    parameter DISP_WIDTH = `DISP_WIDTH
)
(
    // System clock and reset.
    input  wire                  clk_sys_i,
    input  wire                  rst_i,
    // Peripheral driver serial link.
    input  wire                  shift_clk_i,
    input  wire                  serial_frame_select_i,
    input  wire                  drv_serial_data_i,
    output wire                  drv_serial_data_o,
    // Peripheral driver parallel outputs.
    output wire [DRV_WIDTH-1:0]  driver_outputs_o,
    // Display board serial link.
    input  wire                  disp_clk_i,
    input  wire                  disp_serial_data_i,
    input  wire                  disp_strobe_i,
    // Display module side.
    output wire [7:0]            lcd_parallel_data_o,
    output wire                  register_select_bit_o,
    output wire                  display_enable_bit_o,
    output wire                  lcd_byte_valid_o,
    output wire [7:0]            lcd_byte_o,
    output wire                  lcd_byte_is_data_o
);

    // Synchronised link signals and their edges.
    wire                  sclk_fall;
    wire                  sel_level;
    wire                  sel_fall;
    wire                  sel_rise;
    wire                  drv_sdi;
    wire                  dclk_rise;
    wire                  disp_sdi;
    wire                  strobe_level;

    // Peripheral driver state.
    reg  [DRV_WIDTH-1:0]  drv_shift_reg;
    reg  [DRV_WIDTH-1:0]  drv_shift_next;
    reg  [DRV_WIDTH-1:0]  drv_out_reg;
    // Display board state.
    reg  [DISP_WIDTH-1:0] disp_shift_reg;
    reg  [DISP_WIDTH-1:0] disp_latch_reg;
    wire [DISP_WIDTH-1:0] disp_latch_next;
    genvar                gi;
    // Display module capture state.
    reg                   en_prev_reg;
    reg                   byte_valid_reg;
    reg  [7:0]            byte_reg;
    reg                   byte_is_data_reg;

    // Shift clock idles high, so its synchroniser resets high.
    pin_sync
    #(
        .IDLE      (1'b1)
    )
    u_sclk
    (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .pin_i     (shift_clk_i),
        .level_o   (),
        .rise_o    (),
        .fall_o    (sclk_fall)
    );

    // Frame select idles high; its edges open and close a driver frame.
    pin_sync
    #(
        .IDLE      (1'b1)
    )
    u_sel
    (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .pin_i     (serial_frame_select_i),
        .level_o   (sel_level),
        .rise_o    (sel_rise),
        .fall_o    (sel_fall)
    );

    // Driver serial data is only read as a level.
    pin_sync
    #(
        .IDLE      (1'b0)
    )
    u_dsi
    (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .pin_i     (drv_serial_data_i),
        .level_o   (drv_sdi),
        .rise_o    (),
        .fall_o    ()
    );

    // Display clock idles low and shifts on its rising edge.
    pin_sync
    #(
        .IDLE      (1'b0)
    )
    u_dclk
    (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .pin_i     (disp_clk_i),
        .level_o   (),
        .rise_o    (dclk_rise),
        .fall_o    ()
    );

    // Display serial data is only read as a level.
    pin_sync
    #(
        .IDLE      (1'b0)
    )
    u_ddi
    (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .pin_i     (disp_serial_data_i),
        .level_o   (disp_sdi),
        .rise_o    (),
        .fall_o    ()
    );

    // Latch strobe idles low, which keeps the latches closed.
    pin_sync
    #(
        .IDLE      (1'b0)
    )
    u_stb
    (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .pin_i     (disp_strobe_i),
        .level_o   (strobe_level),
        .rise_o    (),
        .fall_o    ()
    );

    // Select falling loads the output states; shift clock falls shift.
    always @*
    begin
        drv_shift_next = drv_shift_reg;
        if (sel_fall)
            drv_shift_next = drv_out_reg;
        else if (sclk_fall && !sel_level)
            drv_shift_next = {drv_shift_reg[DRV_WIDTH-2:0],
                              drv_sdi};
    end

    // Driver outputs take the shifted frame when select returns high.
    always @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            drv_shift_reg <= `DRV_RESET_VALUE;
            drv_out_reg   <= `DRV_RESET_VALUE;
        end
        else
        begin
            drv_shift_reg <= drv_shift_next;
            if (sel_rise)
                drv_out_reg <= drv_shift_reg;
        end
    end

    // Readback leaves from the top stage of the shift register.
    assign drv_serial_data_o = drv_shift_reg[DRV_WIDTH-1];
    assign driver_outputs_o  = drv_out_reg;

    // Display shift register and the register behind the latches.
    always @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            disp_shift_reg <= `DISP_RESET_VALUE;
            disp_latch_reg <= `DISP_RESET_VALUE;
        end
        else
        begin
            if (dclk_rise)
                disp_shift_reg <= {disp_shift_reg[DISP_WIDTH-2:0],
                                   disp_sdi};
            disp_latch_reg <= disp_latch_next;
        end
    end

    // One latch per stage: it follows its stage while the strobe is high.
    generate
        for (gi = 0; gi < DISP_WIDTH; gi = gi + 1)
        begin : g_latch
            assign disp_latch_next[gi] = strobe_level ?
                                         disp_shift_reg[gi] :
                                         disp_latch_reg[gi];
        end
    endgenerate

    assign lcd_parallel_data_o   = disp_latch_reg[7:0];
    assign register_select_bit_o = disp_latch_reg[`DISP_RS_BIT];
    assign display_enable_bit_o  = disp_latch_reg[`DISP_EN_BIT];

    // Display module capture on enable falling edge.
    always @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            en_prev_reg      <= 1'b0;
            byte_valid_reg   <= 1'b0;
            byte_reg         <= 8'h00;
            byte_is_data_reg <= 1'b0;
        end
        else
        begin
            en_prev_reg    <= display_enable_bit_o;
            byte_valid_reg <= en_prev_reg & ~display_enable_bit_o;
            if (en_prev_reg && !display_enable_bit_o)
            begin
                byte_reg         <= lcd_parallel_data_o;
                byte_is_data_reg <= register_select_bit_o;
            end
        end
    end

    assign lcd_byte_valid_o   = byte_valid_reg;
    assign lcd_byte_o         = byte_reg;
    assign lcd_byte_is_data_o = byte_is_data_reg;

endmodule

// >>> test_serial_output_latch_interface.sv
`timescale 1ns/100ps

// Self-checking bench for the latch interface.
module test_serial_output_latch_interface;
    reg        clk_sys_i = 1'b0;
    reg        rst_i = 1'b1;
    wire       sclk, sel, sdo, dclk, dsd, stb, rbk, rs, en, bv, bk;
    wire [7:0] drv, lcd, bo, rb;
    integer    mismatches = 0, n_tests = 0, nb = 0, k;
    reg  [7:0] v, p, gb;
    reg        gk;
    // Design and host.
    serial_output_latch_interface DUT
    (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .shift_clk_i(sclk),
        .serial_frame_select_i(sel), .drv_serial_data_i(sdo),
        .drv_serial_data_o(rbk), .driver_outputs_o(drv), .disp_clk_i(dclk),
        .disp_serial_data_i(dsd), .disp_strobe_i(stb),
        .lcd_parallel_data_o(lcd), .register_select_bit_o(rs),
        .display_enable_bit_o(en), .lcd_byte_valid_o(bv), .lcd_byte_o(bo),
        .lcd_byte_is_data_o(bk)
    );
    host_model HOST
    (
        .clk_sys_i(clk_sys_i), .readback_i(rbk), .sclk_o(sclk), .sel_o(sel),
        .sdo_o(sdo), .rb_o(rb), .dclk_o(dclk), .dsd_o(dsd), .stb_o(stb)
    );
    // Clock and byte recorder, which samples mid-cycle where outputs settle.
    always #2.5 clk_sys_i = ~clk_sys_i;
    always @(negedge clk_sys_i)
        if (bv === 1'b1)
        begin
            nb = nb + 1;
            gb = bo;
            gk = bk;
        end
    // Compare and count.
    task chk(input [9:0] a, input [9:0] e);
        begin
            n_tests = n_tests + 1;
            if (a !== e)
            begin
                mismatches = mismatches + 1;
                $display("CHECK FAILED at %0t: got %h want %h", $time, a, e);
            end
        end
    endtask
    // Verdict.
    task wrap_up;
        begin
            $display("Checks %0d, mismatches %0d", n_tests, mismatches);
            if (mismatches == 0 && n_tests > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    // Watchdog.
    initial
    begin
        #100000 mismatches = mismatches + 1;
        wrap_up;
    end
    // Main sequence.
    initial
    begin
        k = $urandom(32'h36e07c94);
        repeat (6) @(negedge clk_sys_i);
        rst_i = 1'b0;
        #20 chk({rs, en, lcd}, 10'h000);
        chk({2'b00, drv}, 10'h000);
        chk({bv, bk, bo}, 10'h000);
        chk({9'h000, rbk}, 10'h000);
        $display("Reset test done");
        p = 8'h00;
        for (k = 0; k < 6; k = k + 1)
        begin
            v = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : $urandom;
            HOST.drv_frame(v, 1'b1);
            chk(rb, p);
            chk(drv, v);
            p = v;
        end
        HOST.drv_frame(~p, 1'b0);
        chk(drv, p);
        $display("Driver test done");
        for (k = 0; k < 2; k = k + 1)
        begin
            v = $urandom;
            HOST.disp_frame({1'b1, k[0], v}, 1'b1);
            chk({en, rs, lcd}, {1'b1, k[0], v});
            HOST.disp_frame({2'b00, ~v}, 1'b0);
            chk({en, rs, lcd}, {1'b1, k[0], v});
            HOST.disp_frame({1'b0, k[0], v}, 1'b1);
            chk(nb[9:0], k + 1);
            chk({gk, gb}, {k[0], v});
        end
        $display("Display test done");
        wrap_up;
    end
endmodule
